// ===== cmdec_decoder.sv
// cmdec_decoder: fetches opcode and operand bytes and decodes the
// addressing form, effective addresses and branch target.
// assumes program memory answers fetch_req with fetch_valid, and the
// execution side does not write the index bytes while dec_valid is high.
// Operation
// (RULE1) the wait opcode clears the interrupt mask and stops clocking until an interrupt.
// (RULE2) operands follow the opcode in one or two bytes set by the mode.
// (RULE3) a move form takes both source and destination as direct addresses.
// (RULE4) a move form reads direct, writes at the index pointer, then increments it.
// (RULE5) a move form reads at the index pointer, increments it, writes direct.
// (RULE6) a move form takes an immediate byte to a direct destination.
// (RULE7) word-offset indexed adds high-then-low offset bytes to the index.
// (RULE8) byte-offset indexed adds one offset byte to the index.
// (RULE9) stack byte-offset form adds one offset byte to the stack pointer.
// (RULE10) stack word-offset form adds two offset bytes to the stack pointer.
// (RULE11) extended form carries the address high byte then low byte.
// (RULE12) bit-test branches carry a direct address then a signed offset.
// (RULE13) compare-and-branch on the bare index post-increments it.
// (RULE14) compare-and-branch on index plus byte offset post-increments it.
// (RULE15) the index is two addressable bytes forming a 16-bit pointer.
// (RULE16) stack-relative forms use a prefix byte before the indexed opcode.
// (RULE17) bytes come from consecutive addresses and each advances the counter.
`timescale 1ns/10ps
`default_nettype none
module cmdec_decoder (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // program memory fetch
  output logic                   fetch_req,
  output logic [15:0]            fetch_addr,
  input  wire logic              fetch_valid,
  input  wire logic [7:0]        fetch_data,
  // program counter redirect from execution
  input  wire logic              pc_load,
  input  wire logic [15:0]       pc_load_value,
  output logic [15:0]            program_counter,
  // cpu context
  input  wire logic [15:0]       stack_pointer,
  input  wire logic              irq_pending,
  output logic                   imask_clear,
  output logic                   clock_inhibit,
  // index byte writes from execution
  input  wire logic              hx_wr_hi,
  input  wire logic              hx_wr_lo,
  input  wire logic [7:0]        hx_wr_data,
  output logic [7:0]             index_hi,
  output logic [7:0]             index_lo,
  // decoded instruction
  output logic                   dec_valid,
  input  wire logic              dec_ready,
  output var cmdec_pkg::cmdec_dec_t dec_info
);
  typedef enum logic [1:0] {
    st_opcode, st_operand, st_ready, st_wait
  } cmdec_state_t;

  cmdec_state_t          state_r, state_nxt;
  logic [15:0]           pc_r, pc_nxt;
  logic [7:0]            op_r, op_nxt;
  logic                  pre_r, pre_nxt;
  logic [7:0]            b0_r, b0_nxt;
  logic [7:0]            b1_r, b1_nxt;
  logic [1:0]            need_r, need_nxt;
  logic [1:0]            got_r, got_nxt;
  cmdec_pkg::cmdec_dec_t info_r, info_nxt;
  cmdec_pkg::cmdec_form_t form;
  logic                  take;
  logic                  hx_inc;
  logic [15:0]           hx;
  logic [15:0]           ea_base, ea_off, ea_sum;
  logic [15:0]           br_off, br_sum;
  logic [7:0]            rel_byte;

  function automatic cmdec_pkg::cmdec_form_t form_of(
    input logic [7:0] op, input logic pre);
    logic [3:0] h;
    logic [3:0] l;
    cmdec_pkg::cmdec_form_t f;
    h = op[7:4];
    l = op[3:0];
    f.mode    = cmdec_pkg::inherent_mode;
    f.has_rel = 1'b0;
    // (RULE16) prefixed forms
    if (pre)
    begin
      case (h)
        4'h6:
        begin
          f.mode    = cmdec_pkg::stack_byte_offset_mode;
          f.has_rel = (l == 4'h1) || (l == 4'hB);
        end
        4'hD: f.mode = cmdec_pkg::stack_word_offset_mode;
        4'hE: f.mode = cmdec_pkg::stack_byte_offset_mode;
        default: f.mode = cmdec_pkg::inherent_mode;
      endcase
    end
    else
    begin
      case (h)
        // (RULE12) bit test carries direct then offset
        4'h0:
        begin
          f.mode    = cmdec_pkg::direct_mode;
          f.has_rel = 1'b1;
        end
        4'h1: f.mode = cmdec_pkg::direct_mode;
        4'h2:
        begin
          f.mode    = cmdec_pkg::relative_mode;
          f.has_rel = 1'b1;
        end
        4'h3:
        begin
          f.mode    = cmdec_pkg::direct_mode;
          f.has_rel = (l == 4'h1) || (l == 4'hB);
        end
        4'h4, 4'h5:
        begin
          if (l == 4'h1)
          begin
            f.mode    = cmdec_pkg::immediate_mode;
            f.has_rel = 1'b1;
          end
          else if (l == 4'h5)
            f.mode = h[0] ? cmdec_pkg::direct_mode
                          : cmdec_pkg::immediate_word_mode;
          else if (l == 4'hB)
          begin
            f.mode    = cmdec_pkg::relative_mode;
            f.has_rel = 1'b1;
          end
          // (RULE3) (RULE4) direct moves
          else if (l == 4'hE)
            f.mode = h[0] ? cmdec_pkg::direct_to_indexed_postinc_mode
                          : cmdec_pkg::direct_to_direct_mode;
        end
        4'h6, 4'h7:
        begin
          f.mode = h[0] ? cmdec_pkg::indexed_mode
                        : cmdec_pkg::indexed_byte_offset_mode;
          // (RULE13) (RULE14) compare with post increment
          if (l == 4'h1)
          begin
            f.mode    = h[0] ? cmdec_pkg::indexed_postinc_mode
                          : cmdec_pkg::indexed_byte_offset_postinc_mode;
            f.has_rel = 1'b1;
          end
          else if (l == 4'h2)
            f.mode = cmdec_pkg::inherent_mode;
          else if (l == 4'h5)
            f.mode = h[0] ? cmdec_pkg::direct_mode
                          : cmdec_pkg::immediate_word_mode;
          else if (l == 4'hB)
            f.has_rel = 1'b1;
          // (RULE5) (RULE6) moves ending direct
          else if (l == 4'hE)
            f.mode = h[0] ? cmdec_pkg::indexed_postinc_to_direct_mode
                          : cmdec_pkg::immediate_to_direct_mode;
        end
        4'h9:
        begin
          f.has_rel = (l < 4'h4);
          if (l < 4'h4)
            f.mode = cmdec_pkg::relative_mode;
        end
        4'hA:
        begin
          f.has_rel = (l == 4'hD);
          f.mode    = (l == 4'hD) ? cmdec_pkg::relative_mode
                                  : cmdec_pkg::immediate_mode;
        end
        4'hB: f.mode = cmdec_pkg::direct_mode;
        4'hC: f.mode = cmdec_pkg::extended_address_mode;
        4'hD: f.mode = cmdec_pkg::indexed_word_offset_mode;
        4'hE: f.mode = cmdec_pkg::indexed_byte_offset_mode;
        4'hF: f.mode = cmdec_pkg::indexed_mode;
        default: f.mode = cmdec_pkg::inherent_mode;
      endcase
    end
    return f;
  endfunction

  // (RULE2) operand byte count from the form
  function automatic logic [1:0] count_of(
    input cmdec_pkg::cmdec_form_t f);
    logic [1:0] c;
    case (f.mode)
      cmdec_pkg::inherent_mode, cmdec_pkg::relative_mode,
      cmdec_pkg::indexed_mode, cmdec_pkg::indexed_postinc_mode:
        c = 2'h0;
      cmdec_pkg::immediate_word_mode, cmdec_pkg::extended_address_mode,
      cmdec_pkg::indexed_word_offset_mode,
      cmdec_pkg::stack_word_offset_mode,
      cmdec_pkg::direct_to_direct_mode,
      cmdec_pkg::immediate_to_direct_mode:
        c = 2'h2;
      default: c = 2'h1;
    endcase
    return c + {1'b0, f.has_rel};
  endfunction

  // (RULE15) split index register
  cmdec_index u_index (
    .clk     (clk),
    .rst     (rst),
    .wr_hi   (hx_wr_hi),
    .wr_lo   (hx_wr_lo),
    .wr_data (hx_wr_data),
    .inc     (hx_inc),
    .hi      (index_hi),
    .lo      (index_lo)
  );
  assign hx = {index_hi, index_lo};

  cmdec_add #(.W(16)) u_ea (
    .a   (ea_base),
    .b   (ea_off),
    .sum (ea_sum)
  );

  cmdec_add #(.W(16)) u_br (
    .a   (pc_nxt),
    .b   (br_off),
    .sum (br_sum)
  );

  assign take = fetch_req && fetch_valid;

  // (RULE17) sequential fetch and decode sequencing
  always_comb
  begin
    state_nxt   = state_r;
    pc_nxt      = pc_r;
    op_nxt      = op_r;
    pre_nxt     = pre_r;
    b0_nxt      = b0_r;
    b1_nxt      = b1_r;
    need_nxt    = need_r;
    got_nxt     = got_r;
    hx_inc      = 1'b0;
    imask_clear = 1'b0;
    case (state_r)
      st_opcode:
        if (take)
        begin
          pc_nxt = pc_r + 16'h0001;
          // (RULE16) prefix byte, then the indexed opcode
          if (!pre_r && fetch_data == cmdec_pkg::OP_PREFIX)
            pre_nxt = 1'b1;
          else
          begin
            op_nxt    = fetch_data;
            need_nxt  = count_of(form_of(fetch_data, pre_r));
            got_nxt   = 2'h0;
            state_nxt = (need_nxt == 2'h0) ? st_ready : st_operand;
          end
        end
      st_operand:
        if (take)
        begin
          pc_nxt = pc_r + 16'h0001;
          if (got_r == 2'h0)
            b0_nxt = fetch_data;
          else
            b1_nxt = fetch_data;
          got_nxt = got_r + 2'h1;
          if (got_nxt == need_r)
            state_nxt = st_ready;
        end
      st_ready:
        if (dec_ready)
        begin
          pre_nxt   = 1'b0;
          // (RULE13) (RULE14) index steps after the access
          hx_inc    = info_r.postinc;
          state_nxt = st_opcode;
          // (RULE1) mask cleared, clocking held
          if (!info_r.prefixed && info_r.opcode == cmdec_pkg::OP_WAIT)
          begin
            imask_clear = 1'b1;
            state_nxt   = st_wait;
          end
        end
      default:
        if (irq_pending)
          state_nxt = st_opcode;
    endcase
    // a redirect abandons any partly fetched instruction
    if (pc_load)
    begin
      pc_nxt    = pc_load_value;
      pre_nxt   = 1'b0;
      state_nxt = st_opcode;
    end
  end

  // address formation for the instruction being completed
  always_comb
  begin
    form     = form_of(op_nxt, pre_nxt);
    ea_base  = 16'h0000;
    ea_off   = {8'h00, b0_nxt};
    rel_byte = (need_nxt == cmdec_pkg::MAX_OPND) ? b1_nxt : b0_nxt;
    br_off   = {{8{rel_byte[7]}}, rel_byte};
    case (form.mode)
      // (RULE8) index plus byte
      cmdec_pkg::indexed_byte_offset_mode,
      cmdec_pkg::indexed_byte_offset_postinc_mode:
        ea_base = hx;
      // (RULE7) index plus high then low byte
      cmdec_pkg::indexed_word_offset_mode:
      begin
        ea_base = hx;
        ea_off  = {b0_nxt, b1_nxt};
      end
      cmdec_pkg::indexed_mode, cmdec_pkg::indexed_postinc_mode:
      begin
        ea_base = hx;
        ea_off  = 16'h0000;
      end
      // (RULE9) stack plus byte
      cmdec_pkg::stack_byte_offset_mode:
        ea_base = stack_pointer;
      // (RULE10) stack plus word
      cmdec_pkg::stack_word_offset_mode:
      begin
        ea_base = stack_pointer;
        ea_off  = {b0_nxt, b1_nxt};
      end
      // (RULE11) full address, high byte first
      cmdec_pkg::extended_address_mode,
      cmdec_pkg::immediate_word_mode:
        ea_off = {b0_nxt, b1_nxt};
      cmdec_pkg::immediate_to_direct_mode:
        ea_off = {8'h00, b1_nxt};
      default:
        ea_base = 16'h0000;
    endcase
  end

  always_comb
  begin
    info_nxt = info_r;
    if (state_nxt == st_ready && state_r != st_ready)
    begin
      info_nxt.opcode        = op_nxt;
      info_nxt.prefixed      = pre_nxt;
      info_nxt.mode          = form.mode;
      info_nxt.has_rel       = form.has_rel;
      info_nxt.opnd_count    = need_nxt;
      info_nxt.opnd0         = b0_nxt;
      info_nxt.opnd1         = b1_nxt;
      info_nxt.imm           = b0_nxt;
      info_nxt.ea            = ea_sum;
      info_nxt.src_addr      = ea_sum;
      info_nxt.dst_addr      = ea_sum;
      info_nxt.branch_target = br_sum;
      info_nxt.postinc       =
        form.mode == cmdec_pkg::indexed_postinc_mode ||
        form.mode == cmdec_pkg::indexed_byte_offset_postinc_mode ||
        form.mode == cmdec_pkg::direct_to_indexed_postinc_mode ||
        form.mode == cmdec_pkg::indexed_postinc_to_direct_mode;
      case (form.mode)
        // (RULE3) direct to direct
        cmdec_pkg::direct_to_direct_mode:
          info_nxt.dst_addr = {8'h00, b1_nxt};
        // (RULE4) destination at the index pointer
        cmdec_pkg::direct_to_indexed_postinc_mode:
          info_nxt.dst_addr = hx;
        // (RULE5) source at the index pointer
        cmdec_pkg::indexed_postinc_to_direct_mode:
          info_nxt.src_addr = hx;
        // (RULE6) immediate source byte
        cmdec_pkg::immediate_to_direct_mode:
          info_nxt.src_addr = 16'h0000;
        default:
          info_nxt.src_addr = ea_sum;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= st_opcode;
      pc_r    <= cmdec_pkg::PC_RESET;
      op_r    <= 8'h00;
      pre_r   <= 1'b0;
      b0_r    <= 8'h00;
      b1_r    <= 8'h00;
      need_r  <= 2'h0;
      got_r   <= 2'h0;
      info_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      op_r    <= op_nxt;
      pre_r   <= pre_nxt;
      b0_r    <= b0_nxt;
      b1_r    <= b1_nxt;
      need_r  <= need_nxt;
      got_r   <= got_nxt;
      info_r  <= info_nxt;
    end
  end

  assign fetch_req       = state_r == st_opcode || state_r == st_operand;
  assign fetch_addr      = pc_r;
  assign program_counter = pc_r;
  assign dec_valid       = state_r == st_ready;
  assign clock_inhibit   = state_r == st_wait;
  assign dec_info        = info_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_mask_clear: assert property ( // RULE1
    dec_valid && dec_ready && !pc_load && !dec_info.prefixed &&
    dec_info.opcode == cmdec_pkg::OP_WAIT
    |-> imask_clear ##1 (clock_inhibit && !fetch_req))
    else $error("wait did not clear mask and stop");
  a_wait_hold: assert property ( // RULE1
    clock_inhibit && !irq_pending && !pc_load |=> clock_inhibit)
    else $error("clock inhibit dropped without interrupt");
  a_pc_advance: assert property ( // RULE17
    take && !pc_load |=> fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("counter did not step past fetched byte");
  a_opnd_count: assert property ( // RULE2
    dec_valid && dec_info.mode != cmdec_pkg::inherent_mode &&
    dec_info.mode != cmdec_pkg::indexed_mode
    |-> dec_info.opnd_count inside {2'h1, 2'h2})
    else $error("operand count out of range");
  a_word_index: assert property ( // RULE7
    dec_valid &&
    dec_info.mode == cmdec_pkg::indexed_word_offset_mode
    |-> dec_info.ea == hx + {dec_info.opnd0, dec_info.opnd1})
    else $error("word indexed address wrong");
  a_byte_index: assert property ( // RULE8
    dec_valid &&
    dec_info.mode == cmdec_pkg::indexed_byte_offset_mode
    |-> dec_info.ea == hx + {8'h00, dec_info.opnd0})
    else $error("byte indexed address wrong");
  a_stack_offset: assert property ( // RULE10
    dec_valid && dec_info.mode == cmdec_pkg::stack_word_offset_mode
    |-> dec_info.ea == stack_pointer + {dec_info.opnd0, dec_info.opnd1})
    else $error("stack word address wrong");
  a_ext_order: assert property ( // RULE11
    dec_valid &&
    dec_info.mode == cmdec_pkg::extended_address_mode
    |-> dec_info.ea == {dec_info.opnd0, dec_info.opnd1})
    else $error("extended address byte order wrong");
  a_postinc_step: assert property ( // RULE13
    dec_valid && dec_ready && dec_info.postinc && !hx_wr_hi && !hx_wr_lo
    |=> hx == $past(hx) + 16'h0001)
    else $error("index not incremented after access");
  a_move_dst: assert property ( // RULE4
    dec_valid &&
    dec_info.mode == cmdec_pkg::direct_to_indexed_postinc_mode
    |-> dec_info.dst_addr == hx &&
        dec_info.src_addr == {8'h00, dec_info.opnd0})
    else $error("direct to indexed move addresses wrong");

  c_wait_entry: cover property (imask_clear ##1 clock_inhibit);
  c_prefix: cover property (dec_valid && dec_info.prefixed);
  c_postinc: cover property (dec_valid && dec_ready && dec_info.postinc);
  c_move_dd: cover property (
    dec_valid && dec_info.mode == cmdec_pkg::direct_to_direct_mode);
endmodule // cmdec_decoder
`default_nettype wire

// ===== cmdec_pkg.sv
// cmdec_pkg: shared constants and types for the opcode and mode decoder.
// assumes one 8-bit program memory byte stream and a 16-bit address space.
`default_nettype none
package cmdec_pkg;

  localparam logic [7:0]  OP_WAIT     = 8'h8F;
  localparam logic [7:0]  OP_PREFIX   = 8'h9E;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  HX_HI_RESET = 8'h00;
  localparam logic [7:0]  HX_LO_RESET = 8'h00;
  localparam logic [1:0]  MAX_OPND    = 2'h2;

  typedef enum logic [4:0] {
    inherent_mode,
    immediate_mode,
    immediate_word_mode,
    direct_mode,
    extended_address_mode,
    relative_mode,
    indexed_mode,
    indexed_byte_offset_mode,
    indexed_word_offset_mode,
    indexed_postinc_mode,
    indexed_byte_offset_postinc_mode,
    stack_byte_offset_mode,
    stack_word_offset_mode,
    direct_to_direct_mode,
    direct_to_indexed_postinc_mode,
    indexed_postinc_to_direct_mode,
    immediate_to_direct_mode
  } cmdec_mode_t;

  typedef struct packed {
    cmdec_mode_t mode;
    logic        has_rel;
  } cmdec_form_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic        prefixed;
    cmdec_mode_t mode;
    logic        has_rel;
    logic        postinc;
    logic [1:0]  opnd_count;
    logic [7:0]  opnd0;
    logic [7:0]  opnd1;
    logic [7:0]  imm;
    logic [15:0] ea;
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic [15:0] branch_target;
  } cmdec_dec_t;

endpackage
`default_nettype wire

// ===== cmdec_add.sv
// cmdec_add: plain modular adder used for address arithmetic.
// assumes both operands already extended to the full width.
`timescale 1ns/10ps
`default_nettype none
module cmdec_add #(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  // result, carry out dropped on purpose: addresses wrap
  output logic [W-1:0]      sum
);
  assign sum = a + b;
endmodule // cmdec_add
`default_nettype wire

// ===== cmdec_index.sv
// cmdec_index: index register kept as two separately written bytes.
// assumes writer does not load a byte and expect the increment too.
`timescale 1ns/10ps
`default_nettype none
module cmdec_index (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte loads and post increment
  input  wire logic       wr_hi,
  input  wire logic       wr_lo,
  input  wire logic [7:0] wr_data,
  input  wire logic       inc,
  // pointer bytes
  output logic [7:0]      hi,
  output logic [7:0]      lo
);
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic [7:0] lo_r;
  logic [7:0] lo_nxt;

  always_comb
  begin
    {hi_nxt, lo_nxt} = {hi_r, lo_r};
    if (inc)
      {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h0001;
    // explicit byte load beats the increment
    if (wr_hi)
      hi_nxt = wr_data;
    if (wr_lo)
      lo_nxt = wr_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hi_r <= cmdec_pkg::HX_HI_RESET;
      lo_r <= cmdec_pkg::HX_LO_RESET;
    end
    else
    begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  assign hi = hi_r;
  assign lo = lo_r;
endmodule // cmdec_index
`default_nettype wire

// ===== cmdec_mem.sv
// cmdec_mem: program memory model on the decoder fetch port.
// assumes programs sit in the low 256 bytes.
`timescale 1ns/10ps
`default_nettype none
module cmdec_mem (
  // clock
  input  wire logic        clk,
  // fetch port
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  output logic             fetch_valid,
  output logic [7:0]       fetch_data,
  // pacing: answer every other cycle
  input  wire logic        slow
);
  logic [7:0] mem [0:255];
  logic       ph_r;

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h9D;
  end

  always_ff @(posedge clk)
    ph_r <= (ph_r === 1'b1) ? 1'b0 : 1'b1;

  assign fetch_valid = fetch_req && (!slow || ph_r);
  // no stale byte while not answering
  assign fetch_data  = fetch_valid ? mem[fetch_addr[7:0]]
                                   : ~mem[fetch_addr[7:0]];
endmodule // cmdec_mem
`default_nettype wire

// ===== cmdec_decoder_tb.sv
// cmdec_decoder_tb: self-checking bench for the opcode decoder.
// assumes cmdec_mem as program memory; the bench plays execution.
`timescale 1ns/10ps
`default_nettype none
module cmdec_decoder_tb;
  logic                  clk, rst, fetch_req, fetch_valid, pc_load, slow;
  logic                  irq_pending, imask_clear, clock_inhibit;
  logic                  hx_wr_hi, hx_wr_lo, dec_valid, dec_ready;
  logic [15:0]           fetch_addr, pc_load_value, program_counter;
  logic [15:0]           stack_pointer;
  logic [7:0]            fetch_data, hx_wr_data, index_hi, index_lo;
  cmdec_pkg::cmdec_dec_t dec_info;
  int                    errors, n_tests;

  cmdec_decoder DUT (.clk, .rst, .fetch_req, .fetch_addr, .fetch_valid,
    .fetch_data, .pc_load, .pc_load_value, .program_counter,
    .stack_pointer, .irq_pending, .imask_clear, .clock_inhibit,
    .hx_wr_hi, .hx_wr_lo, .hx_wr_data, .index_hi, .index_lo,
    .dec_valid, .dec_ready, .dec_info);
  cmdec_mem u_mem (.clk, .fetch_req, .fetch_addr, .fetch_valid,
    .fetch_data, .slow);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // place an instruction, redirect to it, wait for its decode
  task automatic run_op(input logic [15:0] a, input logic [31:0] b,
                        input int n, input cmdec_pkg::cmdec_mode_t md,
                        input logic [15:0] ea);
    for (int i = 0; i < n; i++)
      u_mem.mem[a[7:0] + 8'(i)] = b[31-8*i -: 8];
    pc_load = 1'b1;
    pc_load_value = a;
    @(posedge clk);
    #1 pc_load = 1'b0;
    for (int i = 0; i < 40 && dec_valid !== 1'b1; i++)
      @(posedge clk) #1;
    chk("valid", 16'(dec_valid), 16'h0001);
    chk("mode", 16'(dec_info.mode), 16'(md));
    chk("cnt", 16'(dec_info.opnd_count),
        16'(n - 1 - int'(b[31:24] == 8'h9E)));
    chk("pc", program_counter, a + 16'(n));
    chk("addr", fetch_addr, a + 16'(n));
    if (md != cmdec_pkg::inherent_mode)
      chk("ea", dec_info.ea, ea);
  endtask

  task automatic accept();
    dec_ready = 1'b1;
    @(posedge clk);
    #1 dec_ready = 1'b0;
  endtask

  task automatic t_ext();
    slow = 1'b1;
    run_op(16'h0010, 32'hC6123400, 3,
           cmdec_pkg::extended_address_mode, 16'h1234);
    slow = 1'b0;
    accept();
  endtask

  task automatic t_index();
    hx_wr_data = 8'h12;
    hx_wr_hi = 1'b1;
    @(posedge clk);
    #1 hx_wr_hi = 1'b0;
    hx_wr_data = 8'hF0;
    hx_wr_lo = 1'b1;
    @(posedge clk);
    #1 hx_wr_lo = 1'b0;
    chk("hx", {index_hi, index_lo}, 16'h12F0);
    run_op(16'h0020, 32'hD6012000, 3,
           cmdec_pkg::indexed_word_offset_mode, 16'h1410);
    run_op(16'h0028, 32'hE6200000, 2,
           cmdec_pkg::indexed_byte_offset_mode, 16'h1310);
  endtask

  task automatic t_stack();
    run_op(16'h0030, 32'h9EE6FF00, 3,
           cmdec_pkg::stack_byte_offset_mode, 16'h02FF);
    chk("pre", 16'(dec_info.prefixed), 16'h0001);
    run_op(16'h0038, 32'h9ED60100, 4,
           cmdec_pkg::stack_word_offset_mode, 16'h0300);
  endtask

  task automatic t_move();
    // moves report the first direct operand address as ea
    run_op(16'h0040, 32'h4E506000, 3,
           cmdec_pkg::direct_to_direct_mode, 16'h0050);
    chk("src", dec_info.src_addr, 16'h0050);
    chk("dst", dec_info.dst_addr, 16'h0060);
    run_op(16'h0048, 32'h5E700000, 2,
           cmdec_pkg::direct_to_indexed_postinc_mode, 16'h0070);
    chk("dst", dec_info.dst_addr, 16'h12F0);
    accept();
    chk("hx", {index_hi, index_lo}, 16'h12F1);
    run_op(16'h0050, 32'h7E800000, 2,
           cmdec_pkg::indexed_postinc_to_direct_mode, 16'h0080);
    chk("src", dec_info.src_addr, 16'h12F1);
    accept();
    chk("hx", {index_hi, index_lo}, 16'h12F2);
    run_op(16'h0058, 32'h6EAA9000, 3,
           cmdec_pkg::immediate_to_direct_mode, 16'h0090);
    chk("imm", 16'(dec_info.imm), 16'h00AA);
  endtask

  task automatic t_branch();
    run_op(16'h0060, 32'h0150F000, 3,
           cmdec_pkg::direct_mode, 16'h0050);
    chk("tgt", dec_info.branch_target, 16'h0053);
    run_op(16'h0068, 32'h71050000, 2,
           cmdec_pkg::indexed_postinc_mode, 16'h12F2);
    chk("tgt", dec_info.branch_target, 16'h006F);
    chk("rel", 16'({dec_info.has_rel, dec_info.postinc}), 16'h0003);
    accept();
    run_op(16'h0070, 32'h6110FE00, 3,
           cmdec_pkg::indexed_byte_offset_postinc_mode, 16'h1303);
    chk("tgt", dec_info.branch_target, 16'h0071);
    accept();
    chk("hx", {index_hi, index_lo}, 16'h12F4);
    run_op(16'h0080, 32'hF6000000, 1,
           cmdec_pkg::indexed_mode, 16'h12F4);
  endtask

  task automatic t_wait();
    run_op(16'h0078, 32'h8F000000, 1,
           cmdec_pkg::inherent_mode, 16'h0000);
    dec_ready = 1'b1;
    #1 chk("imask", 16'(imask_clear), 16'h0001);
    @(posedge clk);
    #1 dec_ready = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("halt", 16'({clock_inhibit, fetch_req}), 16'h0002);
    irq_pending = 1'b1;
    @(posedge clk);
    #1 irq_pending = 1'b0;
    chk("wake", 16'({clock_inhibit, fetch_req}), 16'h0001);
  endtask

  initial
  begin
    #20000;
    errors++;
    wrap_up();
  end

  initial
  begin
    {rst, slow, pc_load, irq_pending, hx_wr_hi, hx_wr_lo} = 6'h20;
    {dec_ready, hx_wr_data, pc_load_value} = 25'h0;
    stack_pointer = 16'h0200;
    #1 chk("pc", program_counter, cmdec_pkg::PC_RESET);
    chk("hx", {index_hi, index_lo}, 16'h0000);
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    t_ext();
    t_index();
    t_stack();
    t_move();
    t_branch();
    t_wait();
    wrap_up();
  end
endmodule // cmdec_decoder_tb
`default_nettype wire
